// ===== common/phy_regs_defs.svh
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PHY_IDX_BASIC_STATUS 6'h01
`define PHY_IDX_OUI_UPPER    6'h02
`define PHY_IDX_OUI_LOWER    6'h03
`define PHY_IDX_AN_ADV       6'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STATUS_EXT_CAP_BIT   0
`define LOWER_OUI_MSB        15
`define LOWER_OUI_LSB        10
`define LOWER_MODEL_MSB      9
`define LOWER_MODEL_LSB      4
`define LOWER_REV_MSB        3
`define LOWER_REV_LSB        0
`define ADV_NEXT_PAGE_BIT    15
`define ADV_REMOTE_FAULT_BIT 13
`define ADV_EXT_NEXT_BIT     12
`define ADV_ASYM_PAUSE_BIT   11
`define ADV_SYM_PAUSE_BIT    10
`define ADV_100_FULL_BIT     8
`define ADV_100_HALF_BIT     7
`define ADV_10_FULL_BIT      6

// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define STATUS_RESET         16'h0001
`define ID_WRITE_MASK        16'hFFFF
`define ADV_WRITE_MASK       16'hBDC0
`define ADV_100_FULL_RESET   1'b1
`define ADV_100_HALF_RESET   1'b1
`define ADV_FIXED_ZERO_RESET 1'b0
`define APB_DATA_ZERO        32'h0000_0000

`endif

// ===== common/phy_regs_pkg.sv
package phy_regs_pkg;

  // Which register an APB address selects
  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_STATUS   = 3'b001,
    SEL_ID_UPPER = 3'b010,
    SEL_ID_LOWER = 3'b011,
    SEL_ADV      = 3'b100
  } reg_sel_t;

  // Registered state of the APB slave
  typedef struct packed {
    logic [31:0] prdata;
    logic        pslverr;
    logic        adv_written;
  } slave_state_t;

endpackage : phy_regs_pkg

// ===== core/strap_defaults.sv
`timescale 1ns/1ps
`default_nettype none

// Reset values of the strap-dependent advertisement bits
module strap_defaults (
  input  wire logic manual_flow_ctrl_cfg_pin,
  input  wire logic full_duplex_flow_ctrl_cfg_pin,
  input  wire logic autoneg_cfg_pin,
  input  wire logic speed_cfg_pin,
  input  wire logic duplex_cfg_pin,
  input  wire logic fx_mode,
  output logic      sym_pause_default,
  output logic      asym_pause_default,
  output logic      fd10_default
);

  always_comb begin
    if (fx_mode) begin
      sym_pause_default  = 1'b0;  // R18
      asym_pause_default = 1'b0;  // R18
      fd10_default       = 1'b0;  // R18
    end else begin
      sym_pause_default  = ~manual_flow_ctrl_cfg_pin;  // R16
      asym_pause_default = ~manual_flow_ctrl_cfg_pin & full_duplex_flow_ctrl_cfg_pin;  // R16
      fd10_default       = autoneg_cfg_pin | (~speed_cfg_pin & duplex_cfg_pin);  // R17
    end
  end

endmodule : strap_defaults

`default_nettype wire

// ===== core/field_reg.sv
`timescale 1ns/1ps
`default_nettype none

// Byte-strobed register; bits outside WRITE_MASK keep their reset value
module field_reg #(
  parameter int                WIDTH      = 16,
  parameter logic [WIDTH-1:0]  WRITE_MASK = '1
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic [WIDTH-1:0]   reset_value,
  input  wire logic               write_en,
  input  wire logic [WIDTH-1:0]   write_data,
  input  wire logic [WIDTH/8-1:0] write_strb,
  output logic      [WIDTH-1:0]   value
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } field_state_t;

  field_state_t state;
  field_state_t next_state;
  logic [WIDTH-1:0] lane_mask;

  genvar lane;
  generate
    for (lane = 0; lane < WIDTH / 8; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{write_strb[lane]}};
    end
  endgenerate

  always_comb begin
    next_state = state;
    if (write_en) begin
      next_state.value = (state.value & ~(WRITE_MASK & lane_mask))
                       | (write_data & WRITE_MASK & lane_mask);
    end
  end

  // Synchronous reset, so loading a strap-derived value here is a clocked capture
  always_ff @(posedge clock) begin
    if (srst) begin
      state.value <= reset_value;
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;

endmodule : field_reg

`default_nettype wire

// ===== core/phy_ident_autoneg_adv_regs.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_defs.svh"

//
// Contract
// R1 - Extended capability status bit 0 is read-only and reads one.
// R2 - Upper ID register, index 2, holds OUI bits 3 to 18.
// R3 - Lower ID register, index 3, holds OUI bits 19 to 24 in 15:10.
// R4 - Lower ID bits 9:4 hold the six-bit model number.
// R5 - Lower ID bits 3:0 hold the revision; its default may vary.
// R6 - Both ID registers are writable and read back as written.
// R7 - Advertisement register, index 4, is read/write ability offered to partner.
// R8 - Bit 15 advertises next page ability; resets to 0.
// R9 - Bit 13 advertises remote fault indication when set.
// R10 - Software always writes 0 to bit 12, extended next page; resets 0.
// R11 - Bit 11 advertises asymmetric pause when set.
// R12 - Bit 10 advertises symmetric pause when set.
// R13 - Bit 8 advertises 100BASE-X full duplex; resets to 1.
// R14 - Bit 7 advertises 100BASE-X half duplex; resets to 1.
// R15 - Bit 6 advertises 10BASE-T full duplex; default from straps.
// R16 - Manual flow strap low: sym pause 1, asym copies strap; else both 0.
// R17 - Bit 6 resets to autoneg strap OR (NOT speed AND duplex).
// R18 - In 100BASE-FX mode pause and 10BASE-T full bits reset 0.
// R19 - Reserved bits 14 and 9 read 0 and ignore writes.
module phy_ident_autoneg_adv_regs
  import phy_regs_pkg::*;
#(
  parameter int          ADDR_W          = 8,
  parameter logic [15:0] OUI_UPPER_RESET = 16'h1234,  // Arbitrary identity value
  parameter logic [5:0]  OUI_LOWER_RESET = 6'h2A,     // Arbitrary identity value
  parameter logic [5:0]  MODEL_RESET     = 6'h15,     // Arbitrary identity value
  parameter logic [3:0]  REVISION_RESET  = 4'h1       // Arbitrary, may differ per silicon
) (
  input  wire logic              clock,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Configuration straps, sampled while srst is high
  input  wire logic              manual_flow_ctrl_cfg_pin,
  input  wire logic              full_duplex_flow_ctrl_cfg_pin,
  input  wire logic              autoneg_cfg_pin,
  input  wire logic              speed_cfg_pin,
  input  wire logic              duplex_cfg_pin,
  input  wire logic              fx_mode,
  // Toward the auto-negotiation engine
  output logic                   adv_next_page,
  output logic                   adv_remote_fault,
  output logic                   adv_ext_next_page,
  output logic                   adv_asym_pause,
  output logic                   adv_sym_pause,
  output logic                   adv_100_full,
  output logic                   adv_100_half,
  output logic                   adv_10_full,
  output logic                   adv_written,
  // Identification as currently stored
  output logic      [15:0]       oui_upper,
  output logic      [5:0]        oui_lower,
  output logic      [5:0]        model_number,
  output logic      [3:0]        revision_number
);

  import phy_regs_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Only word-aligned addresses select a register; anything else is unmapped
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = 6'(addr[ADDR_W-1:2]);
    if (addr[1:0] != 2'b00 || (ADDR_W > 8 && (addr >> 8) != '0)) begin
      return SEL_NONE;
    end
    case (idx)
      `PHY_IDX_BASIC_STATUS: return SEL_STATUS;
      `PHY_IDX_OUI_UPPER:    return SEL_ID_UPPER;
      `PHY_IDX_OUI_LOWER:    return SEL_ID_LOWER;
      `PHY_IDX_AN_ADV:       return SEL_ADV;
      default:               return SEL_NONE;
    endcase
  endfunction : decode_addr

  reg_sel_t sel;
  logic     setup_phase;
  logic     access_phase;
  logic     write_access;

  assign sel          = decode_addr(paddr);
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign write_access = access_phase & pwrite & (sel != SEL_NONE);

  // ----------------------------------------------------------------
  // Strap-derived reset values
  // ----------------------------------------------------------------

  logic sym_pause_default;
  logic asym_pause_default;
  logic fd10_default;

  strap_defaults u_strap_defaults (
    .manual_flow_ctrl_cfg_pin      (manual_flow_ctrl_cfg_pin),
    .full_duplex_flow_ctrl_cfg_pin (full_duplex_flow_ctrl_cfg_pin),
    .autoneg_cfg_pin               (autoneg_cfg_pin),
    .speed_cfg_pin                 (speed_cfg_pin),
    .duplex_cfg_pin                (duplex_cfg_pin),
    .fx_mode                       (fx_mode),
    .sym_pause_default             (sym_pause_default),
    .asym_pause_default            (asym_pause_default),
    .fd10_default                  (fd10_default)
  );

  logic [15:0] adv_reset_value;

  always_comb begin
    adv_reset_value                        = 16'h0000;
    adv_reset_value[`ADV_NEXT_PAGE_BIT]    = `ADV_FIXED_ZERO_RESET;  // R8
    adv_reset_value[`ADV_REMOTE_FAULT_BIT] = `ADV_FIXED_ZERO_RESET;
    adv_reset_value[`ADV_EXT_NEXT_BIT]     = `ADV_FIXED_ZERO_RESET;
    adv_reset_value[`ADV_ASYM_PAUSE_BIT]   = asym_pause_default;     // R16
    adv_reset_value[`ADV_SYM_PAUSE_BIT]    = sym_pause_default;      // R16
    adv_reset_value[`ADV_100_FULL_BIT]     = `ADV_100_FULL_RESET;    // R13
    adv_reset_value[`ADV_100_HALF_BIT]     = `ADV_100_HALF_RESET;    // R14
    adv_reset_value[`ADV_10_FULL_BIT]      = fd10_default;           // R15
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------

  logic [15:0] id_upper_value;
  logic [15:0] id_lower_value;
  logic [15:0] adv_value;
  logic [15:0] id_lower_reset;

  assign id_lower_reset = {OUI_LOWER_RESET, MODEL_RESET, REVISION_RESET};  // R3 R4 R5

  field_reg #(
    .WIDTH      (16),
    .WRITE_MASK (`ID_WRITE_MASK)
  ) u_id_upper (
    .clock       (clock),
    .srst        (srst),
    .reset_value (OUI_UPPER_RESET),
    .write_en    (write_access && sel == SEL_ID_UPPER),  // R6
    .write_data  (pwdata[15:0]),
    .write_strb  (pstrb[1:0]),
    .value       (id_upper_value)
  );

  field_reg #(
    .WIDTH      (16),
    .WRITE_MASK (`ID_WRITE_MASK)
  ) u_id_lower (
    .clock       (clock),
    .srst        (srst),
    .reset_value (id_lower_reset),
    .write_en    (write_access && sel == SEL_ID_LOWER),  // R6
    .write_data  (pwdata[15:0]),
    .write_strb  (pstrb[1:0]),
    .value       (id_lower_value)
  );

  // Reserved bits 14 and 9 are outside the write mask, so they stay zero
  field_reg #(
    .WIDTH      (16),
    .WRITE_MASK (`ADV_WRITE_MASK)
  ) u_adv (
    .clock       (clock),
    .srst        (srst),
    .reset_value (adv_reset_value),
    .write_en    (write_access && sel == SEL_ADV),  // R7 R19
    .write_data  (pwdata[15:0]),
    .write_strb  (pstrb[1:0]),
    .value       (adv_value)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------

  logic [15:0] read_value;

  always_comb begin
    case (sel)
      SEL_STATUS:   read_value = `STATUS_RESET;  // R1
      SEL_ID_UPPER: read_value = id_upper_value;  // R2
      SEL_ID_LOWER: read_value = id_lower_value;  // R3 R4 R5
      SEL_ADV:      read_value = adv_value;  // R7 R19
      default:      read_value = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Slave state
  // ----------------------------------------------------------------

  // Read data and error are captured in the setup cycle so that they leave
  // flip-flops; the price is a fixed access phase of exactly one cycle.
  slave_state_t state;
  slave_state_t next_state;

  always_comb begin
    next_state             = state;
    next_state.adv_written = write_access && sel == SEL_ADV;
    if (setup_phase) begin
      next_state.pslverr = (sel == SEL_NONE);
      if (!pwrite && sel != SEL_NONE) begin
        next_state.prdata = {16'h0000, read_value};
      end else begin
        next_state.prdata = `APB_DATA_ZERO;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state.prdata      <= `APB_DATA_ZERO;
      state.pslverr     <= 1'b0;
      state.adv_written <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign pready  = access_phase;
  assign prdata  = state.prdata;
  assign pslverr = access_phase & state.pslverr;

  assign adv_next_page     = adv_value[`ADV_NEXT_PAGE_BIT];     // R8
  assign adv_remote_fault  = adv_value[`ADV_REMOTE_FAULT_BIT];  // R9
  // Software is expected to keep this at zero; it is passed on as stored
  assign adv_ext_next_page = adv_value[`ADV_EXT_NEXT_BIT];      // R10
  assign adv_asym_pause    = adv_value[`ADV_ASYM_PAUSE_BIT];    // R11
  assign adv_sym_pause     = adv_value[`ADV_SYM_PAUSE_BIT];     // R12
  assign adv_100_full      = adv_value[`ADV_100_FULL_BIT];      // R13
  assign adv_100_half      = adv_value[`ADV_100_HALF_BIT];      // R14
  assign adv_10_full       = adv_value[`ADV_10_FULL_BIT];       // R15
  assign adv_written       = state.adv_written;

  assign oui_upper       = id_upper_value;  // R2
  assign oui_lower       = id_lower_value[`LOWER_OUI_MSB:`LOWER_OUI_LSB];  // R3
  assign model_number    = id_lower_value[`LOWER_MODEL_MSB:`LOWER_MODEL_LSB];  // R4
  assign revision_number = id_lower_value[`LOWER_REV_MSB:`LOWER_REV_LSB];  // R5

endmodule : phy_ident_autoneg_adv_regs

`default_nettype wire

// ===== bench/phy_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// Bus and advertisement checks
// ----------------
module phy_regs_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              adv_next_page,
  input wire logic              adv_remote_fault,
  input wire logic              adv_ext_next_page,
  input wire logic              adv_asym_pause,
  input wire logic              adv_sym_pause,
  input wire logic              adv_100_full,
  input wire logic              adv_100_half,
  input wire logic              adv_10_full,
  input wire logic              adv_written
);
  logic        acc;
  logic        map;
  logic        adv_acc;
  logic [5:0]  idx;
  logic [15:0] adv;
  assign acc = psel && penable;
  assign idx = paddr[7:2];
  assign map = paddr[1:0] == 2'h0 && idx != 6'h00 && idx < 6'h05;
  assign adv_acc = acc && pwrite && map && idx == 6'h04;
  assign adv = {adv_next_page, 1'b0, adv_remote_fault, adv_ext_next_page, adv_asym_pause,
                adv_sym_pause, 1'b0, adv_100_full, adv_100_half, adv_10_full, 6'h00};

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_adv_wr; adv_acc && pstrb[1:0] == 2'h3; endsequence
  sequence s_one_pulse; adv_written ##1 !adv_written; endsequence

  property p_ext_cap; acc && !pwrite && map && idx == 6'h01 |-> prdata == 32'h0000_0001; endproperty
  property p_adv_rd; acc && !pwrite && map && idx == 6'h04 |-> prdata == {16'h0000, adv}; endproperty
  property p_adv_wr; s_adv_wr |=> {16'h0000, adv} == ($past(pwdata) & 32'h0000_BDC0); endproperty
  property p_answer; acc |-> pready && pslverr == !map && (map || prdata == 32'h0); endproperty
  property p_pulse; s_adv_wr |=> s_one_pulse; endproperty
  property p_no_stray; adv_written |-> $past(adv_acc); endproperty
  property p_hold; acc && pwrite && !adv_acc |=> $stable(adv); endproperty
  property p_reset; $fell(srst) |-> adv[15:12] == 4'h0 && adv_100_full && adv_100_half; endproperty

  a_ext_cap: assert property (p_ext_cap) else $error("status read not 0001");
  a_adv_rd: assert property (p_adv_rd) else $error("advertisement read mismatch");
  a_adv_wr: assert property (p_adv_wr) else $error("advertisement write lost");
  a_answer: assert property (p_answer) else $error("bad answer or error flag");
  a_pulse: assert property (p_pulse) else $error("write pulse wrong");
  a_no_stray: assert property (p_no_stray) else $error("stray write pulse");
  a_hold: assert property (p_hold) else $error("advertisement changed by other write");
  a_reset: assert property (p_reset) else $error("advertisement reset wrong");
endmodule : phy_regs_checker

bind phy_ident_autoneg_adv_regs phy_regs_checker #(.ADDR_W(ADDR_W)) phy_regs_checker_i (
  .clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .adv_next_page, .adv_remote_fault, .adv_ext_next_page, .adv_asym_pause, .adv_sym_pause,
  .adv_100_full, .adv_100_half, .adv_10_full, .adv_written);

`default_nettype wire

// ===== bench/apb_host.sv
`timescale 1ns/1ps
`default_nettype none

// Management host; after a transfer paddr and pwdata show the inverse of the last value
module apb_host (
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, pstrb} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic e);
    if (w && a == 8'h10) d[12] = 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    // No local give-up: a slave that never answers is caught by the bench watchdog
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clock);
  endtask : xfer
endmodule : apb_host

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  // Arbitrary identity values
  localparam logic [15:0] UP0 = 16'h5A3C;
  localparam logic [15:0] LO0 = 16'h6EE7;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, adv_written;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        manual_flow_ctrl_cfg_pin = 1'b0, full_duplex_flow_ctrl_cfg_pin = 1'b0, autoneg_cfg_pin = 1'b0;
  logic        speed_cfg_pin = 1'b0, duplex_cfg_pin = 1'b0, fx_mode = 1'b0;
  logic        adv_next_page, adv_remote_fault, adv_ext_next_page, adv_asym_pause;
  logic        adv_sym_pause, adv_100_full, adv_100_half, adv_10_full;
  logic [15:0] oui_upper;
  logic [5:0]  oui_lower, model_number;
  logic [3:0]  revision_number;
  logic [31:0] rs = 32'h64FF;
  logic [31:0] d;
  int          mup, mlo, madv, bad_count = 0, tests_run = 0;
  logic [7:0]  addrs [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h0A, 8'h00, 8'hFC};

  always #5 clock = ~clock;

  phy_ident_autoneg_adv_regs #(.ADDR_W(8), .OUI_UPPER_RESET(UP0), .OUI_LOWER_RESET(LO0[15:10]),
    .MODEL_RESET(LO0[9:4]), .REVISION_RESET(LO0[3:0])) phy_ident_autoneg_adv_regs_i (
    .clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .manual_flow_ctrl_cfg_pin, .full_duplex_flow_ctrl_cfg_pin, .autoneg_cfg_pin, .speed_cfg_pin,
    .duplex_cfg_pin, .fx_mode, .adv_next_page, .adv_remote_fault, .adv_ext_next_page, .adv_asym_pause,
    .adv_sym_pause, .adv_100_full, .adv_100_half, .adv_10_full, .adv_written, .oui_upper, .oui_lower,
    .model_number, .revision_number);
  apb_host apb_host_i (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr);

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic check_outs();
    logic [31:0] v;
    v = {16'h0, adv_next_page, 1'b0, adv_remote_fault, adv_ext_next_page, adv_asym_pause,
         adv_sym_pause, 1'b0, adv_100_full, adv_100_half, adv_10_full, 6'h00};
    check("adv", v, madv);
    check("oui_upper", {16'h0, oui_upper}, mup);
    check("oui_lower", {16'h0, oui_lower, model_number, revision_number}, mlo);
  endtask : check_outs

  // Straps c = {fx, duplex, speed, autoneg, fd flow, manual flow}
  task automatic reset_with(input logic [5:0] c);
    srst <= 1'b1;
    {fx_mode, duplex_cfg_pin, speed_cfg_pin, autoneg_cfg_pin, full_duplex_flow_ctrl_cfg_pin,
     manual_flow_ctrl_cfg_pin} <= c;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    mup = UP0;
    mlo = LO0;
    madv = 32'h180;
    if (!c[5]) madv = madv | {4'h0, ~c[0] & c[1], ~c[0], 3'h0, c[2] | (~c[3] & c[4]), 6'h00};
    @(posedge clock);
  endtask : reset_with

  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic [31:0] x;
    logic        e;
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & (a == 8'h10 ? 16'hADC0 : 16'hFFFF);
    x = a == 8'h04 ? 32'h1 : a == 8'h08 ? mup : a == 8'h0C ? mlo : a == 8'h10 ? madv : 32'h0;
    apb_host_i.xfer(w, a, d, s, q, e);
    check("pslverr", {31'h0, e}, {31'h0, a[1:0] != 2'h0 || a[7:2] == 6'h00 || a[7:2] > 6'h04});
    if (!w) check("prdata", q, x);
    else if (a == 8'h08) mup = (mup & ~m) | (d & m);
    else if (a == 8'h0C) mlo = (mlo & ~m) | (d & m);
    else if (a == 8'h10) madv = (madv & ~m) | (d & m);
    check_outs();
  endtask : op

  // Watchdog: a full run needs about 1240 cycles
  initial begin
    repeat (6000) @(posedge clock);
    bad_count++;
    final_report();
  end

  initial begin
    for (int k = 0; k < 8; k++) begin
      rs = lfsr(rs);
      reset_with({k == 7, rs[4:2], k[1], k[0]});
      check_outs();
      foreach (addrs[i]) op(1'b0, addrs[i], 32'h0, 4'h0);
      repeat (40) begin
        rs = lfsr(rs);
        d = rs;
        rs = lfsr(rs);
        op(rs[31], addrs[rs[2:0]], d, rs[7:4] | {2'h0, rs[8], rs[8]});
      end
    end
    final_report();
  end
endmodule : tb

`default_nettype wire
